// *** irq_seq_pkg.sv ***
// Shared types and constants of the vectored interrupt sequencer.
// Assumes one 250 MHz system clock and a core that acknowledges each request.
package irq_seq_pkg;

  localparam int unsigned VEC_COUNT     = 32;
  localparam int unsigned VEC_IDX_W     = 5;
  localparam int unsigned PRIO_W        = 3;
  localparam int unsigned PRIO_LEVELS   = 8;
  localparam int unsigned ISR_ADDR_W    = 16;
  localparam int unsigned DMA_GROUP_W   = 16;
  localparam int unsigned LEVEL_W       = 4;

  // Evaluation plus presentation, and the acknowledge-to-branch stage
  localparam int unsigned EVAL_CYCLES   = 3;
  localparam int unsigned BRANCH_CYCLES = 7;
  localparam int unsigned BRANCH_CNT_W  = 4;

  // Level seen when nothing is in service
  localparam logic [LEVEL_W-1:0]   LEVEL_NONE       = 4'h8;
  localparam logic [VEC_COUNT-1:0] FIXED_RESERVED   = 32'h0400_0004;
  localparam logic [VEC_COUNT-1:0] VEC_MASK_RESET   = 32'h0000_0000;
  localparam logic [PRIO_LEVELS-1:0] LEVELS_RESET   = 8'h00;

  // Fixed-function source positions
  localparam int unsigned FIX_LOW_VOLTAGE_DETECT = 0;
  localparam int unsigned FIX_FLASH_ECC          = 1;
  localparam int unsigned FIX_SLEEP_MANAGER      = 3;
  localparam int unsigned FIX_PORT_IRQ_UNIT_LO   = 4;
  localparam int unsigned FIX_PORT_IRQ_UNIT_HI   = 12;
  localparam int unsigned FIX_FILTER_BLOCK       = 28;

  typedef enum logic [1:0] {
    SRC_FIXED,
    SRC_DMA,
    SRC_LOGIC,
    SRC_NONE
  } src_sel_t;

  typedef struct packed {
    logic                  enable;
    src_sel_t              src_sel;
    logic [PRIO_W-1:0]     prio;
    logic [ISR_ADDR_W-1:0] isr_address;
  } vec_cfg_t;

endpackage : irq_seq_pkg

// *** irq_vector_slot.sv ***
// One interrupt vector: source select, synchroniser, arrival and posted flags.
// Assumes clear pulses from the sequencer are one cycle wide.
`timescale 1ns/1ps
module irq_vector_slot (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire irq_seq_pkg::vec_cfg_t i_cfg,
  input  wire logic                 i_fixed_src,
  input  wire logic                 i_dma_src,
  input  wire logic                 i_logic_src,
  input  wire logic                 i_sw_set,
  input  wire logic                 i_sw_clear,
  input  wire logic                 i_clr_arrival,
  input  wire logic                 i_clr_posted,
  output logic                      o_arrival,
  output logic                      o_posted
);
  import irq_seq_pkg::*;

  logic sel_src;
  logic sync_q1_r;
  logic sync_q2_r;
  logic sync_q3_r;
  logic req_edge;
  logic sw_clear_d_r;

  always_comb begin
    case (i_cfg.src_sel) // RQ16
      SRC_FIXED: sel_src = i_fixed_src;
      SRC_DMA:   sel_src = i_dma_src;
      SRC_LOGIC: sel_src = i_logic_src;
      default:   sel_src = 1'b0;
    endcase
  end

  // Two-stage synchroniser, then edge detect on the second stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_q1_r <= 1'b0;
      sync_q2_r <= 1'b0;
      sync_q3_r <= 1'b0;
    end else begin
      sync_q1_r <= sel_src; // RQ1
      sync_q2_r <= sync_q1_r; // RQ1
      sync_q3_r <= sync_q2_r;
    end
  end

  assign req_edge = (sync_q2_r && !sync_q3_r) || i_sw_set;

  // Set wins over clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arrival <= 1'b0;
    end else if (req_edge) begin
      o_arrival <= 1'b1; // RQ2
    end else if (i_clr_arrival || i_sw_clear) begin
      o_arrival <= 1'b0; // RQ8
    end
  end

  // Software clear reaches posted a cycle late, once arrival no longer sets it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_clear_d_r <= 1'b0;
    end else begin
      sw_clear_d_r <= i_sw_clear;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_posted <= 1'b0;
    end else if (o_arrival) begin
      o_posted <= 1'b1; // RQ3
    end else if (i_clr_posted || i_sw_clear || sw_clear_d_r) begin
      o_posted <= 1'b0; // RQ8
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_ARRIVAL_SET: assert property (req_edge |=> o_arrival) // RQ2
    else $error("arrival flag not set after request edge");
  AST_POSTED_FOLLOWS: assert property ($rose(o_arrival) |=> o_posted) // RQ3
    else $error("posted flag did not follow arrival flag");
  AST_SYNC_LATENCY: assert property ($rose(sync_q1_r) && !i_sw_set |=> ##1 o_arrival) // RQ1
    else $error("synchronised request not captured in time");

endmodule : irq_vector_slot

// *** irq_sequencer.sv ***
// Vectored interrupt sequencer: 32 vectors, eight nesting levels, core handshake.
// Assumes the core acknowledges a held request and pulses return on completion.
//
// Overview of operation
// RQ1 - Synchronise every asynchronous source before use
// RQ2 - First edge after request sets arrival flag
// RQ3 - Posted flag sets cycle after arrival flag
// RQ4 - Request and vector presented three clocks after
// RQ5 - Drive selected vector's routine address to core
// RQ6 - Core acknowledges a presented request
// RQ7 - Core reads posted address as branch target
// RQ8 - After acknowledge clear arrival, then posted flag
// RQ9 - Acknowledge stage lasts seven cycles until branch
// RQ10 - On completion flag done, restore previous level
// RQ11 - Fixed sources mapped; vectors 2, 26 reserved
// RQ12 - DMA low group below 16, high above
// RQ13 - Capture to branch totals twelve cycles
// RQ14 - Equal priority: lower vector number wins
// RQ15 - Eight writable priority levels, nested service
// RQ16 - Each vector picks fixed, DMA or logic
// RQ17 - Core pops saved counter on return; the core model saves no counter, counts only its acknowledge delay, and only registers the return pulse
`timescale 1ns/1ps
module irq_sequencer #(
  parameter int unsigned BRANCH_LEN = irq_seq_pkg::BRANCH_CYCLES
) (
  input  wire logic                                         i_clk,
  input  wire logic                                         i_rst_n,
  input  wire irq_seq_pkg::vec_cfg_t [irq_seq_pkg::VEC_COUNT-1:0] i_vec_cfg,
  input  wire logic [irq_seq_pkg::VEC_COUNT-1:0]            i_fixed_src,
  input  wire logic [irq_seq_pkg::DMA_GROUP_W-1:0]          i_dma_term_group_lo,
  input  wire logic [irq_seq_pkg::DMA_GROUP_W-1:0]          i_dma_term_group_hi,
  input  wire logic [irq_seq_pkg::VEC_COUNT-1:0]            i_logic_array_irq,
  input  wire logic [irq_seq_pkg::VEC_COUNT-1:0]            i_sw_set,
  input  wire logic [irq_seq_pkg::VEC_COUNT-1:0]            i_sw_clear,
  input  wire logic                                         i_core_acknowledge,
  input  wire logic                                         i_return_from_interrupt,
  output logic                                              o_irq_request,
  output logic [irq_seq_pkg::VEC_IDX_W-1:0]                 o_irq_vector,
  output logic [irq_seq_pkg::ISR_ADDR_W-1:0]                o_isr_address,
  output logic                                              o_service_complete,
  output logic [irq_seq_pkg::PRIO_LEVELS-1:0]               o_active_levels,
  output logic [irq_seq_pkg::VEC_COUNT-1:0]                 o_arrival_flag,
  output logic [irq_seq_pkg::VEC_COUNT-1:0]                 o_posted_flag
);
  import irq_seq_pkg::*;

  if (BRANCH_LEN < 1 || BRANCH_LEN > 15) begin : g_bad_branch_len
    $error("BRANCH_LEN must be 1..15");
  end

  typedef enum logic [2:0] {
    S_IDLE,
    S_EVAL,
    S_PRESENT,
    S_CLR_POSTED_FLAG,
    S_BRANCH
  } seq_state_t;

  seq_state_t                state_r;
  logic [VEC_IDX_W-1:0]      win_idx_r;
  logic [PRIO_W-1:0]         win_prio_r;
  logic [BRANCH_CNT_W-1:0]   branch_cnt_r;
  logic [VEC_COUNT-1:0]      clr_arrival_r;
  logic [VEC_COUNT-1:0]      clr_posted_r;
  logic [VEC_COUNT-1:0]      fixed_masked;
  logic [VEC_COUNT-1:0]      dma_vec;
  logic                      best_found;
  logic [VEC_IDX_W-1:0]      best_idx;
  logic [PRIO_W-1:0]         best_prio;
  logic [LEVEL_W-1:0]        cur_level;
  logic                      take;
  logic [ISR_ADDR_W-1:0]     sel_addr;
  logic [PRIO_LEVELS-1:0]    lowest_active;

  assign fixed_masked = i_fixed_src & ~FIXED_RESERVED; // RQ11
  assign dma_vec      = {i_dma_term_group_hi, i_dma_term_group_lo}; // RQ12

  genvar gv;
  generate
    for (gv = 0; gv < VEC_COUNT; gv++) begin : g_slot
      irq_vector_slot u_slot (
        .i_clk         (i_clk),
        .i_rst_n       (i_rst_n),
        .i_cfg         (i_vec_cfg[gv]),
        .i_fixed_src   (fixed_masked[gv]),
        .i_dma_src     (dma_vec[gv]),
        .i_logic_src   (i_logic_array_irq[gv]),
        .i_sw_set      (i_sw_set[gv]),
        .i_sw_clear    (i_sw_clear[gv]),
        .i_clr_arrival (clr_arrival_r[gv]),
        .i_clr_posted  (clr_posted_r[gv]),
        .o_arrival     (o_arrival_flag[gv]),
        .o_posted      (o_posted_flag[gv])
      );
    end
  endgenerate

  // Lowest priority number wins; strict compare keeps the lower index on ties
  always_comb begin
    best_found = 1'b0;
    best_idx   = '0;
    best_prio  = '0;
    for (int i = 0; i < VEC_COUNT; i++) begin
      if (o_posted_flag[i] && i_vec_cfg[i].enable &&
          (!best_found || i_vec_cfg[i].prio < best_prio)) begin // RQ14
        best_found = 1'b1;
        best_idx   = VEC_IDX_W'(i);
        best_prio  = i_vec_cfg[i].prio;
      end
    end
  end

  // Current in-service level is the most urgent active one
  always_comb begin
    cur_level = LEVEL_NONE;
    for (int l = PRIO_LEVELS - 1; l >= 0; l--) begin
      if (o_active_levels[l]) begin
        cur_level = LEVEL_W'(l);
      end
    end
  end

  assign lowest_active = o_active_levels & (~o_active_levels + 8'h01);
  assign take          = (state_r == S_IDLE) && best_found &&
                         ({1'b0, best_prio} < cur_level); // RQ15
  assign sel_addr      = i_vec_cfg[win_idx_r].isr_address;

  // Handshake sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r      <= S_IDLE;
      win_idx_r    <= '0;
      win_prio_r   <= '0;
      branch_cnt_r <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (take) begin
            win_idx_r  <= best_idx;
            win_prio_r <= best_prio;
            state_r    <= S_EVAL; // RQ4
          end
        end
        S_EVAL: begin
          state_r <= S_PRESENT;
        end
        S_PRESENT: begin
          if (i_core_acknowledge) begin
            state_r <= S_CLR_POSTED_FLAG; // RQ6
          end else if (!o_posted_flag[win_idx_r]) begin
            state_r <= S_IDLE;
          end
        end
        S_CLR_POSTED_FLAG: begin
          branch_cnt_r <= BRANCH_CNT_W'(BRANCH_LEN - 1);
          state_r      <= S_BRANCH;
        end
        S_BRANCH: begin
          if (branch_cnt_r == '0) begin
            state_r <= S_IDLE; // RQ9 RQ13
          end else begin
            branch_cnt_r <= branch_cnt_r - 4'h1;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Request, vector and routine address toward the core
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_request <= 1'b0;
      o_irq_vector  <= '0;
      o_isr_address <= '0;
    end else if (state_r == S_EVAL) begin
      o_irq_request <= 1'b1; // RQ4
      o_irq_vector  <= win_idx_r;
      o_isr_address <= sel_addr; // RQ5
    end else if (state_r == S_PRESENT &&
                 (i_core_acknowledge || !o_posted_flag[win_idx_r])) begin
      o_irq_request <= 1'b0;
    end
  end

  // Arrival clears the cycle after acknowledge, posted one cycle later
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clr_arrival_r <= VEC_MASK_RESET;
      clr_posted_r  <= VEC_MASK_RESET;
    end else begin
      clr_arrival_r <= (state_r == S_PRESENT && i_core_acknowledge) ?
                       (32'h0000_0001 << win_idx_r) : VEC_MASK_RESET; // RQ8
      clr_posted_r  <= clr_arrival_r; // RQ8
    end
  end

  // Active levels: set on entry, most urgent one cleared on return
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_active_levels    <= LEVELS_RESET;
      o_service_complete <= 1'b0;
    end else begin
      o_service_complete <= i_return_from_interrupt && (|o_active_levels); // RQ10
      o_active_levels    <= (o_active_levels &
                            ~(i_return_from_interrupt ? lowest_active : LEVELS_RESET)) |
                            ((state_r == S_CLR_POSTED_FLAG) ? (8'h01 << win_prio_r) : LEVELS_RESET); // RQ10 RQ15
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_REQ_THREE_CLOCKS: assert property (take |-> ##2 o_irq_request) // RQ4
    else $error("request not presented after evaluation");
  AST_ADDR_POSTED: assert property ($rose(o_irq_request) |-> o_isr_address == $past(sel_addr)) // RQ5
    else $error("routine address does not match selected vector");
  AST_REQ_HOLD: assert property (o_irq_request && !i_core_acknowledge && o_posted_flag[o_irq_vector]
                                 |=> o_irq_request) // RQ4
    else $error("request dropped before acknowledge");
  AST_CLEAR_ORDER: assert property (state_r == S_PRESENT && i_core_acknowledge
                                    |=> (clr_arrival_r != '0) ##1 (clr_posted_r == $past(clr_arrival_r))) // RQ8
    else $error("flags not cleared arrival then posted");
  AST_BRANCH_STAGE: assert property (state_r == S_CLR_POSTED_FLAG
                                     |=> (state_r == S_BRANCH)[*7] ##1 (state_r == S_IDLE)) // RQ9
    else $error("acknowledge stage length wrong");
  AST_COMPLETE: assert property (i_return_from_interrupt && (|o_active_levels) && state_r != S_CLR_POSTED_FLAG
                                 |=> o_service_complete && o_active_levels == $past(o_active_levels & ~lowest_active)) // RQ10
    else $error("completion not flagged or level not restored");
  AST_NEST_LEVEL: assert property ($rose(o_irq_request) |-> {1'b0, win_prio_r} < cur_level) // RQ15
    else $error("request presented without beating active level");

  COV_TAKE: cover property (take ##2 o_irq_request);
  COV_ACK: cover property (o_irq_request ##1 i_core_acknowledge);
  COV_NEST: cover property (o_active_levels[0] && o_active_levels[7]);
  COV_RETURN: cover property (o_service_complete);

endmodule : irq_sequencer

// *** core_model.sv ***
// Core model: acknowledges a presented request and pulses return on command.
// Assumes the sequencer holds its request until the acknowledge is sampled.
`timescale 1ns/1ps
module core_model (
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_n,
  input  wire logic                              i_irq_request,
  input  wire logic [irq_seq_pkg::ISR_ADDR_W-1:0] i_isr_address,
  input  wire logic [1:0]                        i_ack_delay,
  input  wire logic                              i_ret_go,
  output logic                                   o_core_acknowledge,
  output logic                                   o_return_from_interrupt,
  output logic [irq_seq_pkg::ISR_ADDR_W-1:0]      o_branch_target
);
  import irq_seq_pkg::*;
  logic [1:0] wait_r;
  // Slow or prompt acknowledge, one cycle wide
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_r <= 2'h0;
      o_core_acknowledge <= 1'b0;
      o_branch_target <= 16'h0000;
    end else if (o_core_acknowledge) begin
      o_core_acknowledge <= 1'b0;
    end else if (i_irq_request && wait_r == i_ack_delay) begin
      o_core_acknowledge <= 1'b1;
      o_branch_target <= i_isr_address;
      wait_r <= 2'h0;
    end else if (i_irq_request) begin
      wait_r <= wait_r + 2'h1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_return_from_interrupt <= 1'b0;
    else o_return_from_interrupt <= i_ret_go;
  end
endmodule : core_model

// *** vectored_interrupt_sequencer_test.sv ***
// Self-checking bench of the interrupt sequencer with a core model.
// Assumes inputs change at the falling edge and BRANCH_LEN of 7.
`timescale 1ns/1ps
module vectored_interrupt_sequencer_test;
  import irq_seq_pkg::*;
  typedef struct packed { logic [4:0] vec; src_sel_t kind; } row_t;
  localparam row_t ROWS [0:6] = '{'{5'h00, SRC_FIXED}, '{5'h0C, SRC_FIXED}, '{5'h1C, SRC_FIXED},
    '{5'h05, SRC_DMA}, '{5'h14, SRC_DMA}, '{5'h09, SRC_LOGIC}, '{5'h1F, SRC_LOGIC}};
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  vec_cfg_t [VEC_COUNT-1:0] cfg;
  logic [31:0]             fixed_src, logic_irq, sw_set, sw_clear, arrival, posted;
  logic [15:0]             dma_lo, dma_hi, addr, target;
  logic                    ack, ret, ret_go, req, done;
  logic [1:0]              ack_delay;
  logic [4:0]              vec;
  logic [7:0]              levels;
  int                      failures, comparisons;
  always #2 clk = ~clk;
  irq_sequencer #(.BRANCH_LEN(7)) u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_vec_cfg(cfg),
    .i_fixed_src(fixed_src), .i_dma_term_group_lo(dma_lo), .i_dma_term_group_hi(dma_hi),
    .i_logic_array_irq(logic_irq), .i_sw_set(sw_set), .i_sw_clear(sw_clear), .i_core_acknowledge(ack),
    .i_return_from_interrupt(ret), .o_irq_request(req), .o_irq_vector(vec), .o_isr_address(addr),
    .o_service_complete(done), .o_active_levels(levels), .o_arrival_flag(arrival), .o_posted_flag(posted));
  core_model u_core (.i_clk(clk), .i_rst_n(rst_n), .i_irq_request(req), .i_isr_address(addr),
    .i_ack_delay(ack_delay), .i_ret_go(ret_go), .o_core_acknowledge(ack), .o_return_from_interrupt(ret),
    .o_branch_target(target));
  task automatic close_out();
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic hang();
    failures++;
    close_out();
  endtask : hang
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic fire(input logic [4:0] v, input src_sel_t k, input logic b);
    case (k)
      SRC_FIXED: fixed_src[v] = b;
      SRC_DMA: if (v < 5'h10) dma_lo[v[3:0]] = b; else dma_hi[v[3:0]] = b;
      default: logic_irq[v] = b;
    endcase
  endtask : fire
  task automatic measure(input logic [4:0] v, input src_sel_t k);
    int ta, tp, tr;
    ta = 0;
    tp = 0;
    tr = 0;
    fire(v, k, 1'b1);
    for (int c = 1; c <= 20 && tr == 0; c++) begin
      @(negedge clk);
      if (ta == 0 && arrival[v] === 1'b1) ta = c;
      if (tp == 0 && posted[v] === 1'b1) tp = c;
      if (req === 1'b1) tr = c;
    end
    fire(v, k, 1'b0);
    chk("arrival_latency", 3, ta);
    chk("posted_latency", 4, tp);
    chk("request_latency", 6, tr);
  endtask : measure
  task automatic take(input logic [4:0] v, input logic [7:0] lv);
    int n;
    n = 0;
    while (req !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 40) hang();
    end
    chk("irq_vector", v, vec);
    chk("isr_address", 16'hA000 | v, addr);
    while (arrival[v] !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 60) hang();
    end
    chk("posted_held", 1, posted[v]);
    @(negedge clk);
    chk("posted_cleared", 0, posted[v]);
    chk("active_levels", lv, levels);
    chk("branch_target", 16'hA000 | v, target);
  endtask : take
  task automatic retire(input logic [7:0] lv);
    int n;
    n = 0;
    ret_go = 1'b1;
    @(negedge clk);
    ret_go = 1'b0;
    while (done !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 8) hang();
    end
    chk("restored_levels", lv, levels);
    @(negedge clk);
    chk("complete_pulse", 0, done);
  endtask : retire
  initial begin
    #100000;
    hang();
  end
  initial begin
    failures = 0;
    comparisons = 0;
    {fixed_src, logic_irq, sw_set, sw_clear, dma_lo, dma_hi} = '0;
    ret_go = 1'b0;
    ack_delay = 2'h0;
    for (int i = 0; i < VEC_COUNT; i++) cfg[i] = '{1'b1, SRC_NONE, 3'h7, 16'hA000 | 16'(i)};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("request_reset", 0, req);
    chk("flags_reset", 0, arrival | posted);
    chk("levels_reset", 0, levels);
    foreach (ROWS[r]) begin
      cfg[ROWS[r].vec].src_sel = ROWS[r].kind;
      measure(ROWS[r].vec, ROWS[r].kind);
      take(ROWS[r].vec, 8'h80);
      retire(8'h00);
      cfg[ROWS[r].vec].src_sel = SRC_NONE;
      repeat (12) @(negedge clk);
    end
    // Tie at one level, then nesting over it
    ack_delay = 2'h2;
    cfg[3].prio = 3'h2;
    cfg[7].prio = 3'h2;
    cfg[1].prio = 3'h0;
    sw_set = 32'h0000_0088;
    @(negedge clk);
    sw_set = '0;
    take(5'h03, 8'h04);
    repeat (12) @(negedge clk);
    chk("nest_blocked", 0, req);
    sw_set = 32'h0000_0002;
    @(negedge clk);
    sw_set = '0;
    take(5'h01, 8'h05);
    repeat (12) @(negedge clk);
    retire(8'h04);
    retire(8'h00);
    take(5'h07, 8'h04);
    retire(8'h00);
    // Disabled vector keeps flags until software clears them
    cfg[10].enable = 1'b0;
    sw_set = 32'h0000_0400;
    @(negedge clk);
    sw_set = '0;
    repeat (6) @(negedge clk);
    chk("disabled_flags", 2'h3, {arrival[10], posted[10]});
    chk("disabled_request", 0, req);
    sw_clear = 32'h0000_0400;
    @(negedge clk);
    sw_clear = '0;
    @(negedge clk);
    chk("cleared_flags", 0, {arrival[10], posted[10]});
    cfg[2].src_sel = SRC_FIXED;
    cfg[26].src_sel = SRC_FIXED;
    fixed_src = 32'h0400_0004;
    repeat (8) @(negedge clk);
    chk("reserved_flags", 0, arrival | posted);
    // Reset in mid-run with a request in flight
    fixed_src = '0;
    sw_set = 32'h0000_0001;
    @(negedge clk);
    sw_set = '0;
    repeat (4) @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk("mid_reset_request", 0, req);
    chk("mid_reset_flags", 0, arrival | posted);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("mid_reset_idle", 0, {req, levels});
    close_out();
  end
endmodule : vectored_interrupt_sequencer_test
